// file: rtl/pio_consts.svh
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH
//
// Behaviour
// - Eleven ports carry 87 bidirectional programmable pins; the input-only pin is extra.
// - Every bidirectional pin has its own direction bit, independent of all others.
// - The input-only pin has no direction bit, no pull-up, always input.
// - One pull-up enable serves each group of four adjacent port pins.
// - An enabled pull-up acts only while the pin's direction is input.
// - Expansion and processor modes ignore pull-ups on ports 0-3, port 4 low, 5.
// - A peripheral output (not D-A) drives its pin whatever the direction bit holds.
// - Each port register is a software-written output latch plus a pin read path.
// - Read-select clear: port one reads pin level on inputs, latch on outputs.
// - Read-select set: port one reads the latch always, whatever the directions.
// - Read-select works with 8-bit external bus in processor or expansion mode.
// - Read-select also works when full-space multiplexed bus frees port one.

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PIO_NUM_PORTS 11
`define PIO_PORT_BITS 8
`define PIO_INPUT_ONLY_PIN 69
`define PIO_PORT_ONE 1
`define PIO_GROUP_SIZE 4

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PIO_PORT_BASE 8'h00
`define PIO_DIR_BASE 8'h10
`define PIO_PULL_BASE 8'h20
`define PIO_PULL_REGS 3
`define PIO_PCTL_ADDR 8'h24
`define PIO_PCTL_RDSEL_BIT 0

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define PIO_DIR_RESET 88'h0
`define PIO_LATCH_RESET 88'h0
`define PIO_PULL_RESET 24'h000000
`define PIO_PULL_VALID 24'h3fffff
`define PIO_PULL_BUSMASK 24'h000dff

`endif

// file: rtl/pio_pkg.sv
package pio_pkg;

    typedef enum logic [1:0]
    {
        PIO_SINGLE_CHIP,
        PIO_MEM_EXPANSION,
        PIO_MICROPROCESSOR
    } pio_mode_t;

    typedef struct packed
    {
        logic out;
        logic oeB;
        logic pull;
    } pio_pad_t;

endpackage : pio_pkg

// file: rtl/pio_pin_cell.sv
module pio_pin_cell #(
    parameter bit INPUT_ONLY = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic dirBit,
    input wire logic latchBit,
    input wire logic periphEn,
    input wire logic periphVal,
    input wire logic pullReq,
    output pio_pkg::pio_pad_t pad
);

    logic drive;

    // Peripheral output overrides the direction bit
    assign drive = (periphEn | dirBit) & ~INPUT_ONLY;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pad.out <= 1'b0;
            pad.oeB <= 1'b1;
            pad.pull <= 1'b0;
        end
        else
        begin
            pad.out <= INPUT_ONLY ? 1'b0 : (periphEn ? periphVal : latchBit);
            pad.oeB <= ~drive;
            pad.pull <= pullReq & ~drive & ~INPUT_ONLY;
        end
    end

endmodule : pio_pin_cell

// file: rtl/pio_pull_map.sv
`include "pio_consts.svh"

module pio_pull_map #(
    parameter int GROUPS = 22
) (
    input wire logic [GROUPS-1:0] pullCtl,
    input wire logic extBus,
    output logic [GROUPS-1:0] groupEn
);

    localparam logic [23:0] BUS_MASK = `PIO_PULL_BUSMASK;

    // Groups shared with the external bus lose their pull-ups there
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : gGrp
            assign groupEn[g] = pullCtl[g] & ~(extBus & BUS_MASK[g]);
        end
    endgenerate

endmodule : pio_pull_map

// file: rtl/programmable_io_ports.sv
`include "pio_consts.svh"

module programmable_io_ports #(
    parameter int NUM_PORTS = `PIO_NUM_PORTS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire pio_pkg::pio_mode_t procMode,
    input wire logic busWidth8,
    input wire logic mpxFullSpace,
    input wire logic [NUM_PORTS*8-1:0] pinIn,
    input wire logic [NUM_PORTS*8-1:0] periphOutEn,
    input wire logic [NUM_PORTS*8-1:0] periphOut,
    output logic [NUM_PORTS*8-1:0] padOut,
    output logic [NUM_PORTS*8-1:0] padOeB,
    output logic [NUM_PORTS*8-1:0] padPullUp
);

    localparam int PINS = NUM_PORTS * `PIO_PORT_BITS;
    localparam int GROUPS = PINS / `PIO_GROUP_SIZE;
    localparam int IONLY = `PIO_INPUT_ONLY_PIN;
    localparam int P1 = `PIO_PORT_ONE;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic inBlock(input logic [7:0] a, input logic [7:0] base,
                                     input logic [7:0] count);
        inBlock = (a >= base) && (a < base + count);
    endfunction : inBlock

    function automatic logic [3:0] blockIdx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        blockIdx = d[3:0];
    endfunction : blockIdx

    localparam logic [7:0] NPORTS8 = 8'(NUM_PORTS);
    localparam logic [7:0] NPULL8 = 8'(`PIO_PULL_REGS);

    logic hitPort;
    logic hitDir;
    logic hitPull;
    logic hitPctl;
    logic [3:0] idx;

    assign hitPort = inBlock(regAddr, `PIO_PORT_BASE, NPORTS8);
    assign hitDir = inBlock(regAddr, `PIO_DIR_BASE, NPORTS8);
    assign hitPull = inBlock(regAddr, `PIO_PULL_BASE, NPULL8);
    assign hitPctl = (regAddr == `PIO_PCTL_ADDR);
    assign idx = hitPort ? blockIdx(regAddr, `PIO_PORT_BASE) :
                 hitDir ? blockIdx(regAddr, `PIO_DIR_BASE) :
                 blockIdx(regAddr, `PIO_PULL_BASE);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [PINS-1:0] latch;
    logic [PINS-1:0] dir;
    logic [23:0] pullCtl;
    logic readSel;
    logic [PINS-1:0] onlyMask;

    always_comb
    begin
        onlyMask = '0;
        onlyMask[IONLY] = 1'b1;
    end

    // Output latch, written by software only
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            latch <= `PIO_LATCH_RESET;
        else if (regWr && hitPort)
            latch[idx*8 +: 8] <= regWdata;
    end

    // One bit per pin; the input-only pin's bit never sets
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            dir <= `PIO_DIR_RESET;
        else if (regWr && hitDir)
            dir[idx*8 +: 8] <= regWdata & ~onlyMask[idx*8 +: 8];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pullCtl <= `PIO_PULL_RESET;
        else if (regWr && hitPull)
            pullCtl[idx*8 +: 8] <= regWdata & 8'(`PIO_PULL_VALID >> (idx*8));
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            readSel <= 1'b0;
        else if (regWr && hitPctl)
            readSel <= regWdata[`PIO_PCTL_RDSEL_BIT];
    end

    // ----------------------------------------------------------------
    // Mode qualification
    // ----------------------------------------------------------------
    logic extBus;
    logic selValid;
    logic p1LatchRead;

    assign extBus = (procMode == pio_pkg::PIO_MEM_EXPANSION) ||
                    (procMode == pio_pkg::PIO_MICROPROCESSOR);
    // Without an 8-bit bus in these modes, or a full-space multiplexed bus, the read-select bit is stored but has no effect
    assign selValid = (extBus && busWidth8) || mpxFullSpace;
    assign p1LatchRead = readSel && selValid;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [PINS-1:0] portView;
    logic [7:0] next_regRdata;

    always_comb
    begin
        portView = (dir & latch) | (~dir & pinIn);
        if (p1LatchRead)
            portView[P1*8 +: 8] = latch[P1*8 +: 8];
    end

    always_comb
    begin
        next_regRdata = 8'h00;
        if (regRd)
        begin
            if (hitPort)
                next_regRdata = portView[idx*8 +: 8];
            else if (hitDir)
                next_regRdata = dir[idx*8 +: 8];
            else if (hitPull)
                next_regRdata = pullCtl[idx*8 +: 8];
            else if (hitPctl)
                next_regRdata = {7'h00, readSel};
        end
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            regRdata <= 8'h00;
        else
            regRdata <= next_regRdata;
    end

    // ----------------------------------------------------------------
    // Pull-up groups and pin cells
    // ----------------------------------------------------------------
    logic [GROUPS-1:0] groupEn;

    pio_pull_map #(
        .GROUPS(GROUPS)
    ) uPull (
        .pullCtl(pullCtl[GROUPS-1:0]),
        .extBus(extBus),
        .groupEn(groupEn)
    );

    genvar i;
    generate
        for (i = 0; i < PINS; i++)
        begin : gPin
            pio_pkg::pio_pad_t pad;

            pio_pin_cell #(
                .INPUT_ONLY(i == IONLY)
            ) uCell (
                .clk(clk),
                .rst_b(rst_b),
                .dirBit(dir[i]),
                .latchBit(latch[i]),
                .periphEn(periphOutEn[i]),
                .periphVal(periphOut[i]),
                .pullReq(groupEn[i/`PIO_GROUP_SIZE]),
                .pad(pad)
            );

            assign padOut[i] = pad.out;
            assign padOeB[i] = pad.oeB;
            assign padPullUp[i] = pad.pull;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Ports 0-3, port 4 low half and port 5 carry the external bus
    function automatic logic busPin(input int k);
        busPin = (k < 36) || (k >= 40 && k < 48);
    endfunction : busPin

    logic [PINS-1:0] driveReq;
    logic [PINS-1:0] periphReq;
    logic [PINS-1:0] pullExp;
    int driveCount;

    assign driveReq = (dir | periphOutEn) & ~onlyMask;
    assign periphReq = periphOutEn & ~onlyMask;

    // Rebuilt pin by pin so a wrong group mask cannot hide
    always_comb
    begin
        pullExp = '0;
        for (int k = 0; k < PINS; k++)
            pullExp[k] = pullCtl[k / `PIO_GROUP_SIZE] && !(extBus && busPin(k));
    end

    always_comb
    begin
        driveCount = 0;
        for (int k = 0; k < PINS; k++)
            driveCount += onlyMask[k] ? 0 : 1;
    end

    pin_count_a: assert property (driveCount == 87)
        else $error("programmable pin count wrong");

    pin_direction_a: assert property (padOeB == ~$past(driveReq))
        else $error("pad enable does not follow direction");

    dir_write_a: assert property (regWr && hitDir |=>
                                  8'(dir >> {$past(idx), 3'b000}) ==
                                  ($past(regWdata) & ~$past(8'(onlyMask >> {idx, 3'b000}))))
        else $error("direction write lost");

    dir_hold_a: assert property (!(regWr && hitDir) |=> $stable(dir))
        else $error("direction changed without a write");

    dir_read_a: assert property (regRd && hitDir |=>
                                 regRdata == $past(8'(dir >> {idx, 3'b000})))
        else $error("direction read wrong");

    input_only_a: assert property (padOeB[IONLY] && !padPullUp[IONLY] && !dir[IONLY])
        else $error("input-only pin drives or pulls");

    ionly_out_a: assert property (!padOut[IONLY])
        else $error("input-only pin shows a drive value");

    pull_group_a: assert property (padPullUp == $past(pullExp & ~driveReq & ~onlyMask))
        else $error("pull-up does not follow its group");

    pull_write_a: assert property (regWr && hitPull |=>
                                   8'(pullCtl >> {$past(idx), 3'b000}) ==
                                   ($past(regWdata) &
                                    8'(`PIO_PULL_VALID >> {$past(idx), 3'b000})))
        else $error("pull-up write lost");

    pull_read_a: assert property (regRd && hitPull |=>
                                  regRdata == $past(8'(pullCtl >> {idx, 3'b000})))
        else $error("pull-up read wrong");

    pull_input_a: assert property ((padPullUp & ~padOeB) == '0)
        else $error("pull-up on a driven pin");

    // Port 4 high half keeps its pull-up in the bus modes
    pull_bus_a: assert property (extBus && $stable(procMode) |=>
                                 (padPullUp[47:0] & 48'hff0fffffffff) == '0)
        else $error("pull-up active on bus ports");

    periph_drive_a: assert property ((padOeB & $past(periphReq)) == '0 &&
                                     ((padOut ^ $past(periphOut)) & $past(periphReq)) == '0)
        else $error("peripheral output not driven");

    pad_latch_a: assert property (((padOut ^ $past(latch)) &
                                   ~$past(periphOutEn) & ~onlyMask) == '0)
        else $error("pad does not show the latch");

    port_latch_a: assert property (regWr && hitPort |=>
                                   8'(latch >> {$past(idx), 3'b000}) == $past(regWdata))
        else $error("latch write lost");

    latch_hold_a: assert property (!(regWr && hitPort) |=> $stable(latch))
        else $error("latch changed without a write");

    port_read_a: assert property (regRd && hitPort && !(idx == 4'(P1) && p1LatchRead)
                                  |=> regRdata == $past(8'(((dir & latch) | (~dir & pinIn)) >>
                                                           {idx, 3'b000})))
        else $error("port read wrong");

    p1_pin_read_a: assert property (regRd && regAddr == 8'(P1) && !p1LatchRead |=>
                                    regRdata == $past((dir[15:8] & latch[15:8]) |
                                                      (~dir[15:8] & pinIn[15:8])))
        else $error("port one pin read wrong");

    p1_latch_read_a: assert property (regRd && regAddr == 8'(P1) && p1LatchRead |=>
                                      regRdata == $past(latch[15:8]))
        else $error("port one latch read wrong");

    sel_write_a: assert property (regWr && hitPctl |=>
                                  readSel == $past(regWdata[`PIO_PCTL_RDSEL_BIT]))
        else $error("read select write lost");

    pctl_read_a: assert property (regRd && hitPctl |=>
                                  regRdata == {7'h00, $past(readSel)})
        else $error("port control read wrong");

    sel_valid_a: assert property (readSel && !extBus && !mpxFullSpace |->
                                  !p1LatchRead)
        else $error("read select effective outside bus modes");

    sel_width_a: assert property (readSel && extBus && !busWidth8 && !mpxFullSpace |->
                                  !p1LatchRead)
        else $error("read select effective on a wide bus");

    sel_bus8_a: assert property (readSel && extBus && busWidth8 |-> p1LatchRead)
        else $error("read select ignored on an 8-bit bus");

    sel_space_a: assert property (readSel && mpxFullSpace |-> p1LatchRead)
        else $error("read select ignored with port one freed");

    reset_state_a: assert property ($rose(rst_b) |-> dir == '0 && pullCtl == '0)
        else $error("registers not cleared by reset");

    reset_regs_a: assert property ($rose(rst_b) |-> latch == '0 && !readSel && regRdata == 8'h00)
        else $error("latch or read data not cleared by reset");

    read_idle_a: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data stands without a read");

    unmapped_read_a: assert property (regRd && !(hitPort || hitDir || hitPull || hitPctl)
                                      |=> regRdata == 8'h00)
        else $error("unmapped read not zero");

    unmapped_write_a: assert property (regWr && !(hitPort || hitDir || hitPull || hitPctl) |=>
                                       $stable(latch) && $stable(dir) && $stable(pullCtl) &&
                                       $stable(readSel))
        else $error("unmapped write changed a register");

endmodule : programmable_io_ports

// file: test/pio_pin_partner.sv
module pio_pin_partner (
    input wire logic clk,
    input wire logic [87:0] padOut,
    input wire logic [87:0] padOeB,
    input wire logic [87:0] padPullUp,
    input wire logic [87:0] extDrive,
    input wire logic [87:0] extVal,
    output logic [87:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [87:0] floatVal = '0;

    // Undriven pins toggle so a stale level never passes for a real one
    always @(posedge clk)
    begin
        floatVal <= ~floatVal;
    end

    always_comb
    begin
        for (int i = 0; i < 88; i++)
        begin
            if (!padOeB[i])
                pinIn[i] = padOut[i];
            else if (extDrive[i])
                pinIn[i] = extVal[i];
            else if (padPullUp[i])
                pinIn[i] = 1'b1;
            else
                pinIn[i] = floatVal[i];
        end
    end
endmodule : pio_pin_partner

// file: test/programmable_io_ports_tb_top.sv
module programmable_io_ports_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] ra; logic [7:0] x;} pio_row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    pio_pkg::pio_mode_t procMode = pio_pkg::PIO_SINGLE_CHIP;
    logic busWidth8 = 1'b0;
    logic mpxFullSpace = 1'b0;
    logic [87:0] pinIn, padOut, padOeB, padPullUp;
    logic [87:0] periphOutEn = '0;
    logic [87:0] periphOut = '0;
    logic [87:0] extDrive = {8'h00, {80{1'b1}}};
    logic [87:0] extVal = {11{8'h3c}};
    logic [7:0] q;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    pio_row_t rows[7] = '{
        '{8'h00, 8'ha5, 8'h00, 8'h3c}, '{8'h10, 8'h0f, 8'h00, 8'h35},
        '{8'h10, 8'hff, 8'h10, 8'hff}, '{8'h18, 8'hff, 8'h18, 8'hdf},
        '{8'h22, 8'hff, 8'h22, 8'h3f}, '{8'h30, 8'hff, 8'h30, 8'h00},
        '{8'h24, 8'h01, 8'h24, 8'h01}};
    pio_pkg::pio_mode_t md[5] = '{pio_pkg::PIO_SINGLE_CHIP, pio_pkg::PIO_MEM_EXPANSION,
        pio_pkg::PIO_MICROPROCESSOR, pio_pkg::PIO_MICROPROCESSOR, pio_pkg::PIO_SINGLE_CHIP};
    logic [4:0] bw = 5'b01010;
    logic [4:0] mpx = 5'b10000;
    logic [7:0] p1x[5] = '{8'h3a, 8'h5a, 8'h3a, 8'h5a, 8'h5a};

    programmable_io_ports i_programmable_io_ports (.clk(clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .procMode(procMode), .busWidth8(busWidth8),
        .mpxFullSpace(mpxFullSpace), .pinIn(pinIn), .periphOutEn(periphOutEn),
        .periphOut(periphOut), .padOut(padOut), .padOeB(padOeB), .padPullUp(padPullUp));
    pio_pin_partner i_pio_pin_partner (.clk(clk), .padOut(padOut), .padOeB(padOeB),
        .padPullUp(padPullUp), .extDrive(extDrive), .extVal(extVal), .pinIn(pinIn));

    always #50 clk = ~clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [87:0] seen, input logic [87:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        r = regRdata;
    endtask : rd

    // Pads lag one clock; pin input is read with no synchroniser
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check(padOeB, {88{1'b1}});
        check(padPullUp, '0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].ra, q);
            check({80'h0, q}, {80'h0, rows[i].x});
        end
        $display("register rows done");
        settle();
        check({80'h0, padOeB[7:0]}, '0);
        check({80'h0, padOut[7:0]}, 88'ha5);
        check({80'h0, padPullUp[71:68]}, '0);
        wr(8'h10, 8'h0c);
        wr(8'h20, 8'h01);
        settle();
        check({80'h0, padPullUp[7:0]}, 88'h03);
        @(posedge clk);
        procMode <= pio_pkg::PIO_MEM_EXPANSION;
        wr(8'h21, 8'h10);
        settle();
        check({84'h0, padPullUp[3:0]}, '0);
        check({84'h0, padPullUp[51:48]}, 88'hf);
        $display("pull test done");
        // Direction left at input; the peripheral drives the pin regardless
        @(posedge clk);
        periphOutEn[16] <= 1'b1;
        periphOut[16] <= 1'b1;
        settle();
        check({86'h0, padOeB[16], padOut[16]}, 88'h1);
        // Pin 72 stands for an analog output: its direction stays input
        check({87'h0, padOeB[72]}, 88'h1);
        $display("peripheral test done");
        wr(8'h01, 8'h5a);
        wr(8'h11, 8'h0f);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            procMode <= md[i];
            busWidth8 <= bw[i];
            mpxFullSpace <= mpx[i];
            settle();
            rd(8'h01, q);
            check({80'h0, q}, {80'h0, p1x[i]});
        end
        wr(8'h24, 8'h00);
        @(posedge clk);
        procMode <= pio_pkg::PIO_MEM_EXPANSION;
        busWidth8 <= 1'b1;
        mpxFullSpace <= 1'b0;
        settle();
        rd(8'h01, q);
        check({80'h0, q}, 88'h3a);
        $display("port one test done");
        for (int p = 0; p < 11; p++)
            wr(8'h10 + 8'(p), 8'hff);
        settle();
        check(88'($countones(~padOeB)), 88'd87);
        @(posedge clk);
        periphOutEn <= '0;
        rst_b <= 1'b0;
        repeat (2) @(negedge clk);
        check(padOeB, {88{1'b1}});
        check(padPullUp, '0);
        @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h10, q);
        check({80'h0, q}, '0);
        $display("reset test done");
        final_report();
    end
endmodule : programmable_io_ports_tb_top
